/* File: logic/itcm_cfg.svh */
// Timing constants for the instruction cycle timing sequencer.
`ifndef ITCM_CFG_SVH
`define ITCM_CFG_SVH
// Clocks in one bus cycle without wait states.
`define ITCM_BUS_CLOCKS 4
// Subtract-quick to a data register: byte/word and long figures.
`define ITCM_SQ_BW_CLOCKS 8
`define ITCM_SQ_L_CLOCKS  12
`define ITCM_SQ_READS     2
`define ITCM_SQ_WRITES    0
`endif

/* File: logic/itcm_pkg.sv */
// Types for the instruction cycle timing sequencer.
`default_nettype none
package itcm_pkg;
  typedef enum logic [1:0] {
    ITCM_IDLE  = 2'b00,
    ITCM_READ  = 2'b01,
    ITCM_WRITE = 2'b11,
    ITCM_INTL  = 2'b10
  } itcm_phase_t;
  typedef enum logic [1:0] {
    ITCM_SZ_BYTE = 2'h0,
    ITCM_SZ_WORD = 2'h1,
    ITCM_SZ_LONG = 2'h2
  } itcm_size_t;
endpackage
`default_nettype wire

/* File: logic/itcm_sequencer.sv */
// Sequencer that plays out one instruction's read, write and idle clocks.
// Notes on behaviour
// - Each read or write bus cycle lasts four clocks without wait states.
// - A slow memory stretches a bus cycle; each wait clock adds to total.
// - Total clocks, read cycles and write cycles are tracked separately.
// - Totals cover instruction fetch, operand fetches, stores, prefetch.
// - Flagged forms add address calculation clocks, reads and writes.
// - Immediate forms cover operand fetch, operation, store and prefetch.
// - Clocks outside bus cycles are idle; no bus cycle is driven then.
// - Subtract-quick to data register: 8(2/0) byte/word, 12(2/0) long.
`timescale 1ns/1ns
`default_nettype none
`include "itcm_cfg.svh"
module itcm_sequencer #(
  parameter int CW = 8
) (
  // Clock, reset and enable.
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic          clk_en,
  // Instruction request; counts include fetch, operands and prefetch.
  input  wire logic          start,
  input  wire logic [CW-1:0] base_clocks,
  input  wire logic [CW-1:0] base_reads,
  input  wire logic [CW-1:0] base_writes,
  input  wire logic          add_ea,
  input  wire logic [CW-1:0] ea_clocks,
  input  wire logic [CW-1:0] ea_reads,
  input  wire logic [CW-1:0] ea_writes,
  // Subtract-quick shortcut to data register; overrides base counts.
  input  wire logic          subtract_quick,
  input  wire logic [1:0]    op_size,
  // Wait request from memory pin, active low.
  input  wire logic          wait_n,
  // Status and bus phase.
  output logic               busy,
  output logic               done,
  output logic               bus_read,
  output logic               bus_write,
  output logic [CW-1:0]      total_clocks,
  output logic [CW-1:0]      read_count,
  output logic [CW-1:0]      write_count,
  output logic [CW-1:0]      idle_count
);
  localparam logic [CW-1:0] BUSC = CW'(`ITCM_BUS_CLOCKS);

  // Two-flop synchroniser for the external wait pin.
  logic wait_s1, wait_s2;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wait_s1 <= 1'b1;
      wait_s2 <= 1'b1;
    end else if (clk_en) begin
      wait_s1 <= wait_n;
      wait_s2 <= wait_s1;
    end
  end

  // Effective counts at start: base, or the subtract-quick figures, plus EA.
  logic [CW-1:0] next_clk, next_rd, next_wr;
  always_comb begin
    if (subtract_quick) begin
      next_clk = (op_size == 2'(itcm_pkg::ITCM_SZ_LONG))
               ? CW'(`ITCM_SQ_L_CLOCKS) : CW'(`ITCM_SQ_BW_CLOCKS);
      next_rd  = CW'(`ITCM_SQ_READS);
      next_wr  = CW'(`ITCM_SQ_WRITES);
    end else begin
      next_clk = base_clocks;
      next_rd  = base_reads;
      next_wr  = base_writes;
    end
    if (add_ea) begin
      next_clk = next_clk + ea_clocks;
      next_rd  = next_rd + ea_reads;
      next_wr  = next_wr + ea_writes;
    end
  end

  // Work remaining for the running instruction.
  itcm_pkg::itcm_phase_t phase;
  logic [CW-1:0] reads_left, writes_left, idle_left;
  logic [2:0]    sub;
  // Stretch only on the last clock of a bus cycle, as memory would.
  logic in_bus, bus_end, stall;
  assign in_bus  = (phase == itcm_pkg::ITCM_READ) ||
                   (phase == itcm_pkg::ITCM_WRITE);
  assign bus_end = in_bus && (sub == 3'(`ITCM_BUS_CLOCKS - 1));
  assign stall   = bus_end && !wait_s2;
  assign bus_read  = (phase == itcm_pkg::ITCM_READ);
  assign bus_write = (phase == itcm_pkg::ITCM_WRITE);
  assign busy      = (phase != itcm_pkg::ITCM_IDLE);

  // Phase sequencing: reads, then writes, then idle internal clocks.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase       <= itcm_pkg::ITCM_IDLE;
      sub         <= 3'h0;
      reads_left  <= '0;
      writes_left <= '0;
      idle_left   <= '0;
      done        <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      case (phase)
        itcm_pkg::ITCM_IDLE: begin
          if (start) begin
            reads_left  <= next_rd;
            writes_left <= next_wr;
            // Idle clocks are what bus cycles leave of the total.
            idle_left   <= next_clk - CW'(BUSC * (next_rd + next_wr));
            sub         <= 3'h0;
            if (next_rd != '0) phase <= itcm_pkg::ITCM_READ;
            else if (next_wr != '0) phase <= itcm_pkg::ITCM_WRITE;
            else phase <= itcm_pkg::ITCM_INTL;
          end
        end
        itcm_pkg::ITCM_READ, itcm_pkg::ITCM_WRITE: begin
          if (!stall) begin
            if (bus_end) begin
              sub <= 3'h0;
              if (phase == itcm_pkg::ITCM_READ) begin
                reads_left <= reads_left - 1'b1;
                if (reads_left > 1) begin
                  phase <= itcm_pkg::ITCM_READ;
                end else if (writes_left != '0) begin
                  phase <= itcm_pkg::ITCM_WRITE;
                end else if (idle_left != '0) begin
                  phase <= itcm_pkg::ITCM_INTL;
                end else begin
                  // No idle clocks left: finish on the last bus clock so an
                  // n(r/0) figure with no idle time costs exactly n clocks.
                  phase <= itcm_pkg::ITCM_IDLE;
                  done  <= 1'b1;
                end
              end else begin
                writes_left <= writes_left - 1'b1;
                if (writes_left <= 1) begin
                  if (idle_left != '0) begin
                    phase <= itcm_pkg::ITCM_INTL;
                  end else begin
                    // Same early finish after the last write cycle.
                    phase <= itcm_pkg::ITCM_IDLE;
                    done  <= 1'b1;
                  end
                end
              end
            end else begin
              sub <= sub + 3'h1;
            end
          end
        end
        // An instruction with no bus cycle still spends one idle clock.
        itcm_pkg::ITCM_INTL: begin
          if (idle_left <= 1) begin
            phase <= itcm_pkg::ITCM_IDLE;
            done  <= 1'b1;
          end
          idle_left <= (idle_left == '0) ? '0 : idle_left - 1'b1;
        end
        default: phase <= itcm_pkg::ITCM_IDLE;
      endcase
    end
  end

  // Separate running counts of clocks, reads, writes and idle clocks.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      total_clocks <= '0;
      read_count   <= '0;
      write_count  <= '0;
      idle_count   <= '0;
    end else if (clk_en) begin
      if (phase == itcm_pkg::ITCM_IDLE && start) begin
        total_clocks <= '0;
        read_count   <= '0;
        write_count  <= '0;
        idle_count   <= '0;
      end else if (busy) begin
        total_clocks <= total_clocks + 1'b1;
        if (bus_end && !stall && bus_read) read_count <= read_count + 1'b1;
        if (bus_end && !stall && bus_write) write_count <= write_count + 1'b1;
        if (phase == itcm_pkg::ITCM_INTL) idle_count <= idle_count + 1'b1;
      end
    end
  end

  // ==========
  // Assertion helpers
  // What each run asked for, and how many wait clocks stretched it, so the
  // finished counts can be judged; wait clocks add to the total alone.
  logic [CW-1:0] req_rd, req_wr, stall_count;
  logic          sq_run, sq_long;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_rd      <= '0;
      req_wr      <= '0;
      sq_run      <= 1'b0;
      sq_long     <= 1'b0;
      stall_count <= '0;
    end else if (clk_en) begin
      if (phase == itcm_pkg::ITCM_IDLE && start) begin
        req_rd      <= next_rd;
        req_wr      <= next_wr;
        sq_run      <= subtract_quick && !add_ea;
        sq_long     <= (op_size == 2'(itcm_pkg::ITCM_SZ_LONG));
        stall_count <= '0;
      end else if (stall) begin
        stall_count <= stall_count + 1'b1;
      end
    end
  end

  // ==========
  // Checks
  // A bus cycle whose first three clocks have the enable high reaches its last clock
  // four clocks in.
  a_bus_four: assert property (@(posedge clock) disable iff (!nrst)
    (in_bus && sub == 3'h0 && clk_en) ##1 clk_en [*2] |=> bus_end)
    else $error("bus cycle not four clocks");
  // A bus cycle that is not stretched ends on its fourth clock.
  a_bus_close: assert property (@(posedge clock) disable iff (!nrst)
    (bus_end && !stall && clk_en) |=> (sub == 3'h0))
    else $error("bus cycle ran past four clocks");
  // Idle clocks count no bus cycle.
  a_idle_nobus: assert property (@(posedge clock) disable iff (!nrst)
    (phase == itcm_pkg::ITCM_INTL && clk_en) |=>
      ($stable(read_count) && $stable(write_count)))
    else $error("bus cycle counted in idle phase");
  // Stall holds the phase.
  a_wait_hold: assert property (@(posedge clock) disable iff (!nrst)
    (stall && clk_en) |=> $stable(phase) && $stable(sub))
    else $error("wait did not stretch cycle");
  // Counts add up when done: four per bus cycle, idle and wait clocks.
  a_sum_total: assert property (@(posedge clock) disable iff (!nrst)
    done |-> total_clocks == CW'(BUSC * (read_count + write_count))
             + idle_count + stall_count)
    else $error("total not four per bus cycle plus idle");
  // Subtract-quick long takes twelve clocks besides wait clocks.
  a_sq_long: assert property (@(posedge clock) disable iff (!nrst)
    (done && sq_run && sq_long) |->
      (total_clocks - stall_count == CW'(`ITCM_SQ_L_CLOCKS)) &&
      (read_count == CW'(`ITCM_SQ_READS)) &&
      (write_count == CW'(`ITCM_SQ_WRITES)))
    else $error("subtract quick long count wrong");
  // Subtract-quick byte or word takes eight clocks besides wait clocks.
  a_sq_short: assert property (@(posedge clock) disable iff (!nrst)
    (done && sq_run && !sq_long) |->
      (total_clocks - stall_count == CW'(`ITCM_SQ_BW_CLOCKS)) &&
      (read_count == CW'(`ITCM_SQ_READS)) &&
      (write_count == CW'(`ITCM_SQ_WRITES)))
    else $error("subtract quick short count wrong");
  // Done stands for one enabled clock only.
  a_done_idle: assert property (@(posedge clock) disable iff (!nrst)
    (done && clk_en) |=> !done)
    else $error("done held past one clock");
  // Finished read and write counts match what the run asked for.
  a_count_match: assert property (@(posedge clock) disable iff (!nrst)
    done |-> (read_count == req_rd) && (write_count == req_wr))
    else $error("read or write count differs from request");
  // A low clock enable freezes the sequence and the total clock count.
  a_freeze_hold: assert property (@(posedge clock) disable iff (!nrst)
    !clk_en |=> $stable(phase) && $stable(sub) && $stable(total_clocks)
                && $stable(done))
    else $error("state moved while clock enable low");
  // Started work leaves idle.
  a_start_busy: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && !busy && start) |=> busy)
    else $error("start ignored");
  // Reads precede writes.
  a_read_first: assert property (@(posedge clock) disable iff (!nrst)
    bus_write |-> reads_left == '0)
    else $error("write before reads finished");
endmodule
`default_nettype wire

/* File: tb/itcm_mem_model.sv */
// Memory model that answers the sequencer's bus cycles fast or slow.
`timescale 1ns/1ns
`default_nettype none
module itcm_mem_model (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic nrst,
  // Bus phase and speed select.
  input  wire logic bus_read,
  input  wire logic bus_write,
  input  wire logic slow,
  // Wait request, active low.
  output logic      wait_n
);
  // ==========
  // Cycle age
  logic [3:0] age;
  // Age saturates so a long burst never wraps into a second stretch.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      age <= 4'h0;
    else if ((bus_read | bus_write) && age != 4'hF)
      age <= age + 4'h1;
    else if (!(bus_read | bus_write))
      age <= 4'h0;
  end
  // A slow memory holds off the first bus cycle of a run.
  assign wait_n = !(slow && (bus_read | bus_write) && age < 4'h6);
endmodule
`default_nettype wire

/* File: tb/tb_itcm_sequencer.sv */
// Self-checking bench for the instruction cycle timing sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb_itcm_sequencer;
  // ==========
  // Signals
  logic clock = 0, nrst = 0, clk_en = 1, start = 0, add_ea = 0;
  logic subtract_quick = 0, slow = 0, wait_n, busy, done, bus_read, bus_write;
  logic [1:0] op_size = 2'h0;
  logic [7:0] base_clocks = 8'h0, base_reads = 8'h0, base_writes = 8'h0;
  logic [7:0] ea_clocks = 8'h0, ea_reads = 8'h0, ea_writes = 8'h0;
  logic [7:0] total_clocks, read_count, write_count, idle_count, nr, nw;
  int err_total = 0, comparisons = 0;
  always #5 clock = ~clock;
  itcm_sequencer #(.CW(8)) u_itcm_sequencer (.clock(clock), .nrst(nrst),
    .clk_en(clk_en), .start(start), .base_clocks(base_clocks),
    .base_reads(base_reads), .base_writes(base_writes), .add_ea(add_ea),
    .ea_clocks(ea_clocks), .ea_reads(ea_reads), .ea_writes(ea_writes),
    .subtract_quick(subtract_quick), .op_size(op_size), .wait_n(wait_n),
    .busy(busy), .done(done), .bus_read(bus_read), .bus_write(bus_write),
    .total_clocks(total_clocks), .read_count(read_count),
    .write_count(write_count), .idle_count(idle_count));
  itcm_mem_model u_itcm_mem_model (.clock(clock), .nrst(nrst),
    .bus_read(bus_read), .bus_write(bus_write), .slow(slow), .wait_n(wait_n));
  // ==========
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t count %h expected %h", $time, got, exp);
    end
  endtask
  // One start pulse, then bus clocks are counted until done, bounded.
  task automatic go;
    nr = 8'h0;
    nw = 8'h0;
    @(posedge clock) #1 start = 1;
    @(posedge clock) #1 start = 0;
    for (int i = 0; i < 300 && done !== 1'b1; i++) begin
      nr += 8'(bus_read === 1'b1);
      nw += 8'(bus_write === 1'b1);
      @(posedge clock) #1;
    end
    chk(8'(done), 8'h1);
  endtask
  task automatic counts(input logic [7:0] t, r, w, i);
    chk(total_clocks, t);
    chk(read_count, r);
    chk(write_count, w);
    chk(idle_count, i);
  endtask
  // ==========
  // Scenarios
  task automatic t_quick;
    subtract_quick = 1;
    for (int s = 0; s < 3; s++) begin
      op_size = 2'(s);
      go();
      if (s == 2) counts(8'd12, 8'd2, 8'd0, 8'd4);
      else counts(8'd8, 8'd2, 8'd0, 8'd0);
      chk(nr, 8'd8);
    end
    subtract_quick = 0;
  endtask
  // Immediate to memory plus address time: 20(4/1) and 4(1/0).
  task automatic t_imm;
    {base_clocks, base_reads, base_writes} = {8'd20, 8'd4, 8'd1};
    {add_ea, ea_clocks, ea_reads, ea_writes} = {1'b1, 8'd4, 8'd1, 8'd0};
    go();
    counts(8'd24, 8'd5, 8'd1, 8'd0);
    chk(nw, 8'd4);
    add_ea = 0;
  endtask
  // Slow memory: 16(4/0) grows by exactly the stretched clocks.
  task automatic t_wait;
    {base_clocks, base_reads, base_writes} = {8'd16, 8'd4, 8'd0};
    slow = 1;
    go();
    slow = 0;
    chk(8'(nr > 8'd16), 8'h1);
    counts(nr, 8'd4, 8'd0, 8'd0);
  endtask
  // Clock enable low mid-run freezes the total count; 16(2/1) still ends at 16.
  task automatic t_freeze;
    logic [7:0] held;
    {base_clocks, base_reads, base_writes} = {8'd16, 8'd2, 8'd1};
    @(posedge clock) #1 start = 1;
    @(posedge clock) #1 start = 0;
    repeat (4) @(posedge clock);
    #1 clk_en = 0;
    held = total_clocks;
    repeat (6) @(posedge clock);
    #1 chk(total_clocks, held);
    chk(8'(bus_read), 8'h1);
    clk_en = 1;
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge clock) #1;
    chk(8'(done), 8'h1);
    counts(8'd16, 8'd2, 8'd1, 8'd4);
  endtask
  // Reset in mid-run clears all counts; a later 12(1/1) runs normally.
  task automatic t_reset;
    {base_clocks, base_reads, base_writes} = {8'd12, 8'd1, 8'd1};
    @(posedge clock) #1 start = 1;
    @(posedge clock) #1 start = 0;
    repeat (6) @(posedge clock);
    #1 nrst = 0;
    #1 chk(8'(busy), 8'h0);
    counts(8'd0, 8'd0, 8'd0, 8'd0);
    repeat (2) @(posedge clock);
    #1 nrst = 1;
    go();
    counts(8'd12, 8'd1, 8'd1, 8'd4);
    chk(nw, 8'd4);
  endtask
  task automatic wrap_up;
    $display("err_total=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence after eight clocks of reset.
  initial begin
    repeat (8) @(posedge clock);
    #1 nrst = 1;
    counts(8'd0, 8'd0, 8'd0, 8'd0);
    t_quick();
    t_imm();
    t_wait();
    t_freeze();
    t_reset();
    wrap_up();
  end
  // A hang is cut short well past the expected run.
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
